//--- verification/pmbus_host_model.sv
// Purpose: host side of the decoded command port
// Assumes: requests launched just after a rising edge
// Notes: idle lines show the inverse of the last value
`timescale 1ns/100ps
module pmbus_host_model (
  input wire logic clk,
  output logic [7:0] cmd_code,
  output logic cmd_wr,
  output logic [15:0] cmd_wdata,
  output logic cmd_rd,
  input wire logic [15:0] cmd_rdata,
  input wire logic cmd_bad
);
  initial begin
    cmd_code = 8'h00;
    cmd_wr = 1'b0;
    cmd_wdata = 16'h0000;
    cmd_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] c, input logic [15:0] v);
    @(posedge clk);
    cmd_code <= c;
    cmd_wdata <= v;
    cmd_wr <= 1'b1;
    @(posedge clk);
    cmd_wr <= 1'b0;
    cmd_code <= ~c;
    cmd_wdata <= ~v;
  endtask
  task automatic rd(input logic [7:0] c, output logic [15:0] v,
    output logic bad);
    @(posedge clk);
    cmd_code <= c;
    cmd_rd <= 1'b1;
    @(posedge clk);
    cmd_rd <= 1'b0;
    cmd_code <= ~c;
    #1;
    bad = cmd_bad;
    @(posedge clk);
    #1;
    v = cmd_rdata;
  endtask
endmodule

//--- verification/vout_fault_chk.sv
// Purpose: port assertions for the output fault bank
// Assumes: one clock domain, reset asynchronous and active high
// Notes: attached by bind below the module
`timescale 1ns/100ps
module vout_fault_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] cmd_code,
  input wire logic cmd_wr,
  input wire logic [15:0] cmd_wdata,
  input wire logic cmd_rd,
  input wire logic [15:0] cmd_rdata,
  input wire logic cmd_bad,
  input wire logic [15:0] iout_raw,
  input wire logic ov_fault,
  input wire logic [15:0] iout_report,
  input wire logic phase_tick
);
  logic acc;
  logic unm;
  assign acc = cmd_wr | cmd_rd;
  assign unm = !(cmd_code inside {8'h03, 8'h35, 8'h36, 8'h37, 8'h39,
    8'h40, 8'h41, 8'h42, 8'h43, 8'h44});
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence wr_lim;
    cmd_wr && !cmd_rd && cmd_code == 8'h40;
  endsequence
  sequence rd_lim;
    cmd_rd && !cmd_wr && cmd_code == 8'h40;
  endsequence
  chk_bad_raise : assert property (
    acc && unm |=> cmd_bad) else $error("unmapped access not flagged");
  chk_bad_quiet : assert property (
    !(acc && unm) |=> !cmd_bad) else $error("bad flag without cause");
  chk_unmapped_zero : assert property (
    cmd_rd && unm |=> cmd_rdata == 16'h0000)
    else $error("unmapped read not zero");
  chk_rdata_hold : assert property (
    !cmd_rd |=> $stable(cmd_rdata)) else $error("read data moved");
  chk_limit_echo : assert property (
    wr_lim ##2 rd_lim |=> cmd_rdata == $past(cmd_wdata, 3))
    else $error("fault limit readback wrong");
  chk_fault_sticky : assert property (
    ov_fault && !(cmd_wr && cmd_code == 8'h03) |=> ov_fault)
    else $error("fault flag dropped without clear");
  chk_offset_exp : assert property (
    !$past(rst) && !$past(rst, 2)
      |-> iout_report[15:11] == $past(iout_raw[15:11]))
    else $error("current exponent not passed through");
  chk_tick_pulse : assert property (
    phase_tick |=> !phase_tick) else $error("phase tick too long");
endmodule
bind vout_fault_limit_config vout_fault_chk vout_fault_chk_i (
  .clk(clk), .rst(rst), .cmd_code(cmd_code), .cmd_wr(cmd_wr),
  .cmd_wdata(cmd_wdata), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata),
  .cmd_bad(cmd_bad), .iout_raw(iout_raw), .ov_fault(ov_fault),
  .iout_report(iout_report), .phase_tick(phase_tick)
);

//--- verification/vout_fault_limit_config_bench.sv
// Purpose: self-checking bench for the output fault bank
// Assumes: linear inputs use exponent zero
// Notes: host model carries the command tasks
`timescale 1ns/100ps
module vout_fault_limit_config_bench;
  logic clk;
  logic rst;
  logic [15:0] vin_meas, vout_meas, iout_raw, unit_cycles;
  logic sync_in;
  logic [7:0] cmd_code;
  logic cmd_wr, cmd_rd, cmd_bad, conv_on, out_en, ov_fault, ov_warn;
  logic uv_warn, uv_fault, phase_tick;
  logic [15:0] cmd_wdata, cmd_rdata, iout_report, d;
  logic b;
  int mismatches = 0;
  int tests_run = 0;
  int ticks = 0;
  int n;
  int t0;
  logic [7:0] codes [9] = '{8'h35, 8'h36, 8'h37, 8'h39, 8'h40, 8'h41,
    8'h42, 8'h43, 8'h44};
  logic [15:0] rv [9] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'hFFFF, 16'h0080, 16'hFFFF, 16'h0000, 16'h0000};
  logic [15:0] msk [9] = '{16'hFFFF, 16'hFFFF, 16'h0FFF, 16'hFFFF,
    16'hFFFF, 16'h00FF, 16'hFFFF, 16'hFFFF, 16'hFFFF};
  vout_fault_limit_config vout_fault_limit_config_i (.clk(clk), .rst(rst),
    .cmd_code(cmd_code), .cmd_wr(cmd_wr), .cmd_wdata(cmd_wdata),
    .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata), .cmd_bad(cmd_bad),
    .vin_meas(vin_meas), .vout_meas(vout_meas), .iout_raw(iout_raw),
    .unit_cycles(unit_cycles), .sync_in(sync_in), .conv_on(conv_on),
    .out_en(out_en), .ov_fault(ov_fault), .ov_warn(ov_warn),
    .uv_warn(uv_warn), .uv_fault(uv_fault), .iout_report(iout_report),
    .phase_tick(phase_tick));
  pmbus_host_model pmbus_host_model_i (.clk(clk), .cmd_code(cmd_code),
    .cmd_wr(cmd_wr), .cmd_wdata(cmd_wdata), .cmd_rd(cmd_rd),
    .cmd_rdata(cmd_rdata), .cmd_bad(cmd_bad));
  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input string nm, input logic [15:0] s,
    input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic flag(input string nm, input logic s, input logic e);
    chk(nm, {15'h0000, s}, {15'h0000, e});
  endtask
  task automatic w(input logic [7:0] c, input logic [15:0] v);
    pmbus_host_model_i.wr(c, v);
  endtask
  task automatic rdchk(input string nm, input logic [7:0] c,
    input logic [15:0] e);
    pmbus_host_model_i.rd(c, d, b);
    chk(nm, d, e);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic meas(input logic [15:0] vi, input logic [15:0] vo);
    @(posedge clk);
    vin_meas <= vi;
    vout_meas <= vo;
  endtask
  // one cycle above the fault limit, then back to normal
  task automatic pulse;
    meas(vin_meas, 16'h6001);
    meas(vin_meas, 16'h3000);
    cyc(2);
  endtask
  task automatic wait_en(input logic v, input int lim);
    n = 0;
    while (out_en !== v && n < lim) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // count on the falling edge so the registered pulse has settled
  always @(negedge clk) begin
    if (phase_tick === 1'b1)
      ticks <= ticks + 1;
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    final_report;
  end
  initial begin
    rst = 1'b1;
    vin_meas = 16'h0000;
    vout_meas = 16'h3000;
    iout_raw = 16'h0010;
    unit_cycles = 16'h0004;
    sync_in = 1'b0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      rdchk("reset value", codes[i], rv[i]);
      w(codes[i], 16'hA5C3);
      rdchk("readback", codes[i], 16'hA5C3 & msk[i]);
    end
    w(8'h38, 16'h1234);
    pmbus_host_model_i.rd(8'h38, d, b);
    chk("unmapped read", d, 16'h0000);
    flag("unmapped flag", b, 1'b1);
    $display("test registers done");
    w(8'h35, 16'h0030);
    w(8'h36, 16'h0026);
    w(8'h41, 16'h0000);
    w(8'h40, 16'h6000);
    meas(16'h0020, 16'h3000);
    cyc(3);
    flag("conv below start", conv_on, 1'b0);
    meas(16'h0030, 16'h3000);
    cyc(3);
    flag("conv at start", conv_on, 1'b1);
    meas(16'h0028, 16'h3000);
    cyc(3);
    flag("conv above stop", conv_on, 1'b1);
    meas(16'h0026, 16'h3000);
    cyc(3);
    flag("conv at stop", conv_on, 1'b0);
    meas(16'h0040, 16'h3000);
    cyc(3);
    flag("output on", out_en, 1'b1);
    $display("test conversion done");
    w(8'h42, 16'h5000);
    w(8'h43, 16'h2000);
    w(8'h44, 16'h1000);
    meas(16'h0040, 16'h5001);
    cyc(3);
    flag("high warn", ov_warn, 1'b1);
    meas(16'h0040, 16'h1FFF);
    cyc(3);
    flag("low warn", uv_warn, 1'b1);
    flag("high warn clear", ov_warn, 1'b0);
    meas(16'h0040, 16'h0FFF);
    cyc(3);
    flag("low fault", uv_fault, 1'b1);
    meas(16'h0040, 16'h6001);
    cyc(3);
    flag("fault seen", ov_fault, 1'b1);
    flag("ignore keeps on", out_en, 1'b1);
    meas(16'h0040, 16'h3000);
    w(8'h03, 16'h0000);
    cyc(2);
    flag("fault cleared", ov_fault, 1'b0);
    $display("test limits done");
    w(8'h41, 16'h00C0);
    meas(16'h0040, 16'h6001);
    cyc(3);
    flag("resume off", out_en, 1'b0);
    meas(16'h0040, 16'h3000);
    wait_en(1'b1, 10);
    flag("resume on", out_en, 1'b1);
    w(8'h41, 16'h0080);
    w(8'h03, 16'h0000);
    pulse;
    flag("disable off", out_en, 1'b0);
    cyc(20);
    flag("no retry latched", out_en, 1'b0);
    w(8'h03, 16'h0000);
    wait_en(1'b1, 10);
    flag("clear restarts", out_en, 1'b1);
    w(8'h41, 16'h008B);
    w(8'h03, 16'h0000);
    pulse;
    cyc(22);
    flag("delay running", out_en, 1'b0);
    wait_en(1'b1, 20);
    flag("one retry", out_en, 1'b1);
    pulse;
    cyc(40);
    flag("retries used", out_en, 1'b0);
    w(8'h41, 16'h004B);
    w(8'h03, 16'h0000);
    wait_en(1'b1, 10);
    meas(16'h0040, 16'h6001);
    cyc(25);
    flag("operate in delay", out_en, 1'b1);
    wait_en(1'b0, 20);
    flag("off after delay", out_en, 1'b0);
    meas(16'h0040, 16'h3000);
    wait_en(1'b1, 60);
    flag("delayed retry", out_en, 1'b1);
    w(8'h41, 16'h00B8);
    w(8'h03, 16'h0000);
    @(posedge clk);
    unit_cycles <= 16'h0008;
    for (int i = 0; i < 3; i++) begin
      pulse;
      flag("endless off", out_en, 1'b0);
      wait_en(1'b1, 20);
      flag("endless on", out_en, 1'b1);
    end
    $display("test actions done");
    w(8'h39, 16'h0005);
    cyc(3);
    chk("current report", iout_report, 16'h0015);
    w(8'h37, 16'h0421);
    rdchk("phase fields", 8'h37, 16'h0421);
    for (int i = 0; i < 12; i++) begin
      if (i == 4)
        t0 = ticks;
      @(posedge clk);
      sync_in <= 1'b1;
      repeat (19) @(posedge clk);
      sync_in <= 1'b0;
      repeat (20) @(posedge clk);
    end
    chk("ticks", 16'(ticks - t0), 16'h0008);
    $display("test phase done");
    final_report;
  end
endmodule

//--- verilog/fault_delay_timer.sv
// Purpose: counts a delay of two to the code time units
// Assumes: unit length arrives in clock cycles, zero acts as one
// Notes: a start while busy restarts the count
`timescale 1ns/100ps
`include "vout_fault_cfg.svh"
module fault_delay_timer (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic abort,
  input wire logic [2:0] code,
  input wire logic [15:0] unit_cycles,
  output logic done
);

  vout_fault_pkg::timer_s q;
  vout_fault_pkg::timer_s d;

  always_comb begin
    d = q;
    d.done = 1'b0;
    if (abort) begin
      d.busy = 1'b0;
    end else if (start) begin
      d.busy = 1'b1;
      d.unit_cnt = 16'h0000;
      d.units_left = 8'(8'h01 << code);
    end else if (q.busy) begin
      if (q.unit_cnt + 16'h0001 >= unit_cycles) begin
        d.unit_cnt = 16'h0000;
        d.units_left = q.units_left - 8'h01;
        if (q.units_left == 8'h01) begin
          d.busy = 1'b0;
          d.done = 1'b1;
        end
      end else begin
        d.unit_cnt = q.unit_cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign done = q.done;

endmodule

//--- verilog/vout_fault_cfg.svh
// Purpose: constants for the output fault limit and configuration bank
// Assumes: command codes are eight bits and data words sixteen bits
// Notes: rule overview below
//
// Overview of operation
// - Stop conversion once input voltage falls to the stop threshold.
// - Start conversion only when input voltage reaches the start threshold.
// - Offset switching phase from the shared sync clock per interleave.
// - Group identifier is unsigned 0..15 in bits 11:8.
// - Unit count including sync driver is unsigned 0..15 in bits 7:4.
// - Add programmed current offset to every reported current reading.
// - Over-voltage fault limit is 16-bit unsigned, exponent minus eleven.
// - Action code 00 keeps operating while the fault exists.
// - Code 01 keeps operating for the delay, then follows retries.
// - Code 10 disables output at once, then follows retries.
// - Code 11 disables output only while the fault persists.
// - Bits 5:3 give the number of restart attempts after shutdown.
// - Retry 000 never restarts; output stays off until faults cleared.
// - Retry 111 restarts without limit.
// - Bits 2:0 give delay of two to the code units, 1..128.
// - One delay unit length comes from a separate register; here it comes from the unit_cycles input port.
// - Over-voltage warning limit is 16-bit unsigned, exponent minus eleven.
// - Under-voltage warning limit is 16-bit unsigned, exponent -11.
// - Under-voltage fault limit is 16-bit unsigned, exponent -11.
`ifndef VOUT_FAULT_CFG_SVH
`define VOUT_FAULT_CFG_SVH

// ****************************************
// command codes
// ****************************************
`define CMD_CLEAR_FAULTS 8'h03
`define CMD_START_THR 8'h35
`define CMD_STOP_THR 8'h36
`define CMD_PHASE 8'h37
`define CMD_IOFF 8'h39
`define CMD_OVF_LIM 8'h40
`define CMD_OVF_ACT 8'h41
`define CMD_OVW_LIM 8'h42
`define CMD_UVW_LIM 8'h43
`define CMD_UVF_LIM 8'h44

// ****************************************
// reset values
// ****************************************
`define RST_START_THR 16'h0000
`define RST_STOP_THR 16'h0000
`define RST_PHASE 12'h000
`define RST_IOFF 16'h0000
`define RST_OVF_LIM 16'hFFFF
`define RST_OVF_ACT 8'h80
`define RST_OVW_LIM 16'hFFFF
`define RST_UVW_LIM 16'h0000
`define RST_UVF_LIM 16'h0000

// ****************************************
// fields
// ****************************************
`define PH_GROUP_HI 11
`define PH_GROUP_LO 8
`define PH_RAILS_HI 7
`define PH_RAILS_LO 4
`define PH_POS_HI 3
`define PH_POS_LO 0
`define ACT_RESP_HI 7
`define ACT_RESP_LO 6
`define ACT_RETRY_HI 5
`define ACT_RETRY_LO 3
`define ACT_DLY_HI 2
`define ACT_DLY_LO 0
`define RESP_IGNORE 2'h0
`define RESP_DELAYED 2'h1
`define RESP_DISABLE 2'h2
`define RESP_RESUME 2'h3
`define RETRY_NONE 3'h0
`define RETRY_FOREVER 3'h7
`define VOUT_EXP (-11)
`define LIN_MANT_HI 10
`define LIN_EXP_LO 11
`define LIN_FRAC 8

`endif

//--- verilog/vout_fault_limit_config.sv
// Purpose: output fault limits, fault action, interleave and offsets
// Assumes: measurements come from logic on clk; sync_in is a pin
// Notes: command port is the decoded command layer of the serial bus
`timescale 1ns/100ps
`include "vout_fault_cfg.svh"
module vout_fault_limit_config (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] cmd_code,
  input wire logic cmd_wr,
  input wire logic [15:0] cmd_wdata,
  input wire logic cmd_rd,
  output logic [15:0] cmd_rdata,
  output logic cmd_bad,
  input wire logic [15:0] vin_meas,
  input wire logic [15:0] vout_meas,
  input wire logic [15:0] iout_raw,
  input wire logic [15:0] unit_cycles,
  input wire logic sync_in,
  output logic conv_on,
  output logic out_en,
  output logic ov_fault,
  output logic ov_warn,
  output logic uv_warn,
  output logic uv_fault,
  output logic [15:0] iout_report,
  output logic phase_tick
);

  localparam vout_fault_pkg::bank_s RST_VAL = '{
    start_thr: `RST_START_THR,
    stop_thr: `RST_STOP_THR,
    phase: `RST_PHASE,
    ioff: `RST_IOFF,
    ovf_lim: `RST_OVF_LIM,
    ovf_act: `RST_OVF_ACT,
    ovw_lim: `RST_OVW_LIM,
    uvw_lim: `RST_UVW_LIM,
    uvf_lim: `RST_UVF_LIM,
    rdata: 16'h0000,
    bad: 1'b0,
    conv_on: 1'b0,
    state: vout_fault_pkg::ST_RUN,
    tries_left: 3'h0,
    out_en: 1'b0,
    ov_fault: 1'b0,
    ov_warn: 1'b0,
    uv_warn: 1'b0,
    uv_fault: 1'b0,
    iout_rep: 16'h0000,
    sync1: 1'b0,
    sync2: 1'b0,
    sync3: 1'b0,
    ph_cnt: 16'h0000,
    period: 16'h0000,
    armed: 1'b0,
    phase_tick: 1'b0
  };

  vout_fault_pkg::bank_s q;
  vout_fault_pkg::bank_s d;
  logic tmr_start;
  logic tmr_abort;
  logic tmr_done;

  // ****************************************
  // linear word to unsigned fixed point
  // ****************************************
  function automatic logic [31:0] lin_fix(input logic [15:0] v);
    logic signed [5:0] sh;
    logic [31:0] m;
    sh = 6'($signed(v[15:`LIN_EXP_LO])) + 6'(`LIN_FRAC);
    m = {21'h000000, v[`LIN_MANT_HI:0]};
    if (v[`LIN_MANT_HI]) begin
      lin_fix = 32'h00000000;
    end else if (sh >= 0) begin
      lin_fix = m << sh;
    end else begin
      lin_fix = m >> (-sh);
    end
  endfunction

  // ****************************************
  // fault action helpers
  // ****************************************
  logic [1:0] resp;
  logic [2:0] retry_set;
  logic ov_now;
  logic clear_cmd;
  logic vin_ok_start;
  logic vin_low_stop;
  logic [3:0] rails;
  logic [3:0] pos;
  logic [19:0] ph_lhs;
  logic [19:0] ph_rhs;
  logic sync_rise;

  assign resp = q.ovf_act[`ACT_RESP_HI:`ACT_RESP_LO];
  assign retry_set = q.ovf_act[`ACT_RETRY_HI:`ACT_RETRY_LO];
  assign ov_now = vout_meas > q.ovf_lim;
  assign clear_cmd = cmd_wr && cmd_code == `CMD_CLEAR_FAULTS;
  assign vin_ok_start = lin_fix(vin_meas) >= lin_fix(q.start_thr);
  assign vin_low_stop = lin_fix(vin_meas) <= lin_fix(q.stop_thr);
  assign rails = q.phase[`PH_RAILS_HI:`PH_RAILS_LO];
  assign pos = q.phase[`PH_POS_HI:`PH_POS_LO];
  assign ph_lhs = q.ph_cnt * rails;
  assign ph_rhs = (pos < rails) ? q.period * pos : 20'h00000;
  assign sync_rise = q.sync2 && !q.sync3;

  always_comb begin
    d = q;
    d.bad = 1'b0;
    d.phase_tick = 1'b0;
    tmr_start = 1'b0;
    tmr_abort = 1'b0;

    // ****************************************
    // command port
    // ****************************************
    if (cmd_wr) begin
      case (cmd_code)
        `CMD_CLEAR_FAULTS: d.bad = 1'b0;
        `CMD_START_THR: d.start_thr = cmd_wdata;
        `CMD_STOP_THR: d.stop_thr = cmd_wdata;
        `CMD_PHASE: d.phase = cmd_wdata[11:0];
        `CMD_IOFF: d.ioff = cmd_wdata;
        `CMD_OVF_LIM: d.ovf_lim = cmd_wdata;
        `CMD_OVF_ACT: d.ovf_act = cmd_wdata[7:0];
        `CMD_OVW_LIM: d.ovw_lim = cmd_wdata;
        `CMD_UVW_LIM: d.uvw_lim = cmd_wdata;
        `CMD_UVF_LIM: d.uvf_lim = cmd_wdata;
        default: d.bad = 1'b1;
      endcase
    end
    if (cmd_rd) begin
      case (cmd_code)
        `CMD_START_THR: d.rdata = q.start_thr;
        `CMD_STOP_THR: d.rdata = q.stop_thr;
        `CMD_PHASE: d.rdata = {4'h0, q.phase};
        `CMD_IOFF: d.rdata = q.ioff;
        `CMD_OVF_LIM: d.rdata = q.ovf_lim;
        `CMD_OVF_ACT: d.rdata = {8'h00, q.ovf_act};
        `CMD_OVW_LIM: d.rdata = q.ovw_lim;
        `CMD_UVW_LIM: d.rdata = q.uvw_lim;
        `CMD_UVF_LIM: d.rdata = q.uvf_lim;
        default: begin
          d.rdata = 16'h0000;
          d.bad = 1'b1;
        end
      endcase
    end

    // ****************************************
    // conversion run control
    // ****************************************
    if (!q.conv_on && vin_ok_start) begin
      d.conv_on = 1'b1;
    end else if (q.conv_on && vin_low_stop) begin
      d.conv_on = 1'b0;
    end

    // ****************************************
    // warnings and sticky fault flag
    // ****************************************
    d.ov_warn = vout_meas > q.ovw_lim;
    d.uv_warn = q.conv_on && vout_meas < q.uvw_lim;
    d.uv_fault = q.conv_on && vout_meas < q.uvf_lim;
    if (clear_cmd) begin
      d.ov_fault = 1'b0;
    end
    if (q.conv_on && ov_now) begin
      d.ov_fault = 1'b1;
    end

    // ****************************************
    // over-voltage fault action
    // ****************************************
    if (!q.conv_on) begin
      d.state = vout_fault_pkg::ST_RUN;
      d.tries_left = retry_set;
      tmr_abort = 1'b1;
    end else begin
      case (q.state)
        vout_fault_pkg::ST_RUN: begin
          if (ov_now) begin
            case (resp)
              `RESP_IGNORE: d.state = vout_fault_pkg::ST_RUN;
              `RESP_DELAYED: begin
                tmr_start = 1'b1;
                d.state = vout_fault_pkg::ST_GRACE;
              end
              `RESP_DISABLE: begin
                if (q.tries_left == `RETRY_NONE) begin
                  d.state = vout_fault_pkg::ST_LATCHED;
                end else begin
                  tmr_start = 1'b1;
                  d.state = vout_fault_pkg::ST_RETRY_WAIT;
                end
              end
              default: d.state = vout_fault_pkg::ST_HOLD_OFF;
            endcase
          end
        end
        vout_fault_pkg::ST_GRACE: begin
          if (!ov_now) begin
            tmr_abort = 1'b1;
            d.state = vout_fault_pkg::ST_RUN;
          end else if (tmr_done) begin
            if (q.tries_left == `RETRY_NONE) begin
              d.state = vout_fault_pkg::ST_LATCHED;
            end else begin
              tmr_start = 1'b1;
              d.state = vout_fault_pkg::ST_RETRY_WAIT;
            end
          end
        end
        vout_fault_pkg::ST_RETRY_WAIT: begin
          if (tmr_done) begin
            d.state = vout_fault_pkg::ST_RUN;
            if (q.tries_left != `RETRY_FOREVER) begin
              d.tries_left = q.tries_left - 3'h1;
            end
          end
        end
        vout_fault_pkg::ST_HOLD_OFF: begin
          if (!ov_now) begin
            d.state = vout_fault_pkg::ST_RUN;
          end
        end
        vout_fault_pkg::ST_LATCHED: begin
          if (clear_cmd) begin
            d.state = vout_fault_pkg::ST_RUN;
            d.tries_left = retry_set;
          end
        end
        default: d.state = vout_fault_pkg::ST_RUN;
      endcase
      // clear-faults rearms the programmed retry budget in any state
      if (clear_cmd) begin
        d.tries_left = retry_set;
      end
    end
    d.out_en = d.conv_on && (d.state == vout_fault_pkg::ST_RUN ||
      d.state == vout_fault_pkg::ST_GRACE);

    // ****************************************
    // current reading offset
    // ****************************************
    d.iout_rep = {iout_raw[15:`LIN_EXP_LO],
      11'(iout_raw[`LIN_MANT_HI:0] + q.ioff[`LIN_MANT_HI:0])};

    // ****************************************
    // interleave phase against sync clock
    // ****************************************
    d.sync1 = sync_in;
    d.sync2 = q.sync1;
    d.sync3 = q.sync2;
    if (sync_rise) begin
      d.period = q.ph_cnt + 16'h0001;
      d.ph_cnt = 16'h0000;
      d.armed = 1'b1;
    end else begin
      if (q.ph_cnt != 16'hFFFF) begin
        d.ph_cnt = q.ph_cnt + 16'h0001;
      end
      if (q.armed && ph_lhs >= ph_rhs) begin
        d.phase_tick = 1'b1;
        d.armed = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= RST_VAL;
    end else begin
      q <= d;
    end
  end

  fault_delay_timer u_timer (
    .clk(clk),
    .rst(rst),
    .start(tmr_start),
    .abort(tmr_abort),
    .code(q.ovf_act[`ACT_DLY_HI:`ACT_DLY_LO]),
    .unit_cycles(unit_cycles),
    .done(tmr_done)
  );

  assign cmd_rdata = q.rdata;
  assign cmd_bad = q.bad;
  assign conv_on = q.conv_on;
  assign out_en = q.out_en;
  assign ov_fault = q.ov_fault;
  assign ov_warn = q.ov_warn;
  assign uv_warn = q.uv_warn;
  assign uv_fault = q.uv_fault;
  assign iout_report = q.iout_rep;
  assign phase_tick = q.phase_tick;

endmodule

//--- verilog/vout_fault_pkg.sv
// Purpose: types for the output fault limit and configuration bank
// Assumes: constants live in vout_fault_cfg.svh
// Notes: state encodings are one-hot
package vout_fault_pkg;

  typedef enum logic [4:0] {
    ST_RUN = 5'h01,
    ST_GRACE = 5'h02,
    ST_RETRY_WAIT = 5'h04,
    ST_HOLD_OFF = 5'h08,
    ST_LATCHED = 5'h10
  } fault_state_e;

  typedef struct packed {
    logic [15:0] unit_cnt;
    logic [7:0] units_left;
    logic busy;
    logic done;
  } timer_s;

  typedef struct packed {
    logic [15:0] start_thr;
    logic [15:0] stop_thr;
    logic [11:0] phase;
    logic [15:0] ioff;
    logic [15:0] ovf_lim;
    logic [7:0] ovf_act;
    logic [15:0] ovw_lim;
    logic [15:0] uvw_lim;
    logic [15:0] uvf_lim;
    logic [15:0] rdata;
    logic bad;
    logic conv_on;
    fault_state_e state;
    logic [2:0] tries_left;
    logic out_en;
    logic ov_fault;
    logic ov_warn;
    logic uv_warn;
    logic uv_fault;
    logic [15:0] iout_rep;
    logic sync1;
    logic sync2;
    logic sync3;
    logic [15:0] ph_cnt;
    logic [15:0] period;
    logic armed;
    logic phase_tick;
  } bank_s;

endpackage
